// file: shared/primary_pointer_defs.svh
`ifndef POINTER_DEFS_SVH
`define POINTER_DEFS_SVH

// register word indices; the bus byte address is four times the index
`define IDX_POINTER_LOW 8'h82
`define IDX_POINTER_HIGH 8'h83
`define IDX_AUX_CONTROL 8'ha2
`define IDX_CORE_OP 8'hc0

// auxiliary control field positions
`define AUX_SEL_BIT 0
`define AUX_ZERO_BIT 1
`define AUX_FLAG_BIT 3

// reset values
`define POINTER_RESET 16'h0000
`define AUX_RESET 8'h00

// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// file: shared/primary_pointer_pkg.sv
package ptr_op_pkg;
   typedef enum logic [1:0] {
      OP_NONE,
      OP_INC_POINTER,
      OP_INC_AUX
   } core_op_t;
endpackage

// file: rtl/aux_control_reg.sv
`timescale 1ns/1ps
`include "primary_pointer_defs.svh"
module aux_control_reg (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   input wire logic inc_en,
   output logic [7:0] value,
   output logic select
);
   logic [7:0] aux_r;
   logic [7:0] aux_nxt;
   logic [7:0] inc_sum;

   // hard-wired zero absorbs the carry, so only the select bit moves
   always_comb begin
      inc_sum = aux_r + 8'h01;
      aux_nxt = aux_r;
      if (wr_en) begin
         aux_nxt = wr_data;
      end else if (inc_en) begin
         aux_nxt = inc_sum;
      end
      aux_nxt[`AUX_ZERO_BIT] = 1'b0;
      aux_nxt[2] = 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aux_r <= `AUX_RESET;
      end else begin
         aux_r <= aux_nxt;
      end
   end

   assign value = aux_r;
   assign select = aux_r[`AUX_SEL_BIT];
endmodule

// file: rtl/pointer_bank.sv
`timescale 1ns/1ps
`include "primary_pointer_defs.svh"
module pointer_bank (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic select,
   input wire logic wr_low,
   input wire logic wr_high,
   input wire logic [7:0] wr_data,
   input wire logic inc_en,
   output logic [15:0] active
);
   logic [15:0] ptr_r [0:1];

   // only the selected entry ever changes; the other keeps its value
   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_ptr
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               ptr_r[i] <= `POINTER_RESET;
            end else if (select == 1'(i)) begin
               if (wr_low) begin
                  ptr_r[i][7:0] <= wr_data;
               end else if (wr_high) begin
                  ptr_r[i][15:8] <= wr_data;
               end else if (inc_en) begin
                  ptr_r[i] <= ptr_r[i] + 16'h0001;
               end
            end
         end
      end
   endgenerate

   assign active = ptr_r[select];
endmodule

// file: rtl/dual_data_pointer_select.sv
`timescale 1ns/1ps
`include "primary_pointer_defs.svh"
module dual_data_pointer_select (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [15:0] mem_address,
   output logic pointer_select,
   output logic user_flag_two
);

   ////////////////////////////////////////////////////////////////////////
   // write channel

   logic [11:0] awaddr_r;
   logic aw_have_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic w_have_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic awready_r;
   logic wready_r;
   logic do_write;
   logic [9:0] wr_index;
   logic wr_lane0;

   assign do_write = aw_have_r && w_have_r && !bvalid_r;
   assign wr_index = awaddr_r[11:2];
   assign wr_lane0 = wstrb_r[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         awaddr_r <= 12'h000;
         awready_r <= 1'b0;
      end else if (do_write) begin
         aw_have_r <= 1'b0;
         awready_r <= 1'b0;
      end else if (s_axi_awvalid && awready_r) begin
         aw_have_r <= 1'b1;
         awaddr_r <= s_axi_awaddr;
         awready_r <= 1'b0;
      end else begin
         awready_r <= !aw_have_r && !bvalid_r;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         wready_r <= 1'b0;
      end else if (do_write) begin
         w_have_r <= 1'b0;
         wready_r <= 1'b0;
      end else if (s_axi_wvalid && wready_r) begin
         w_have_r <= 1'b1;
         wdata_r <= s_axi_wdata;
         wstrb_r <= s_axi_wstrb;
         wready_r <= 1'b0;
      end else begin
         wready_r <= !w_have_r && !bvalid_r;
      end
   end

   logic wr_hit;
   always_comb begin
      wr_hit = (wr_index == {2'b00, `IDX_POINTER_LOW}) ||
               (wr_index == {2'b00, `IDX_POINTER_HIGH}) ||
               (wr_index == {2'b00, `IDX_AUX_CONTROL}) ||
               (wr_index == {2'b00, `IDX_CORE_OP});
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= `RESP_OKAY;
      end else if (do_write) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   ////////////////////////////////////////////////////////////////////////
   // register strobes; byte lane 0 only, upper lanes have no storage

   logic wr_low;
   logic wr_high;
   logic wr_aux;
   logic wr_op;
   ptr_op_pkg::core_op_t op_code;
   logic inc_pointer;
   logic inc_aux;

   assign wr_low = do_write && wr_lane0 &&
                   wr_index == {2'b00, `IDX_POINTER_LOW};
   assign wr_high = do_write && wr_lane0 &&
                    wr_index == {2'b00, `IDX_POINTER_HIGH};
   assign wr_aux = do_write && wr_lane0 &&
                   wr_index == {2'b00, `IDX_AUX_CONTROL};
   assign wr_op = do_write && wr_lane0 &&
                  wr_index == {2'b00, `IDX_CORE_OP};

   // the op register stands in for the core's inc instructions
   always_comb begin
      op_code = ptr_op_pkg::OP_NONE;
      if (wr_op) begin
         case (wdata_r[1:0])
            2'h1: op_code = ptr_op_pkg::OP_INC_POINTER;
            2'h2: op_code = ptr_op_pkg::OP_INC_AUX;
            default: op_code = ptr_op_pkg::OP_NONE;
         endcase
      end
   end

   assign inc_pointer = (op_code == ptr_op_pkg::OP_INC_POINTER);
   assign inc_aux = (op_code == ptr_op_pkg::OP_INC_AUX);

   ////////////////////////////////////////////////////////////////////////
   // storage

   logic [7:0] aux_value;
   logic sel;
   logic [15:0] active;

   aux_control_reg u_aux (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr_en(wr_aux),
      .wr_data(wdata_r[7:0]),
      .inc_en(inc_aux),
      .value(aux_value),
      .select(sel)
   );

   pointer_bank u_bank (
      .aclk(aclk),
      .aresetn(aresetn),
      .select(sel),
      .wr_low(wr_low),
      .wr_high(wr_high),
      .wr_data(wdata_r[7:0]),
      .inc_en(inc_pointer),
      .active(active)
   );

   ////////////////////////////////////////////////////////////////////////
   // core-facing outputs, registered; one cycle behind the storage

   logic [15:0] mem_address_r;
   logic pointer_select_r;
   logic user_flag_two_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mem_address_r <= `POINTER_RESET;
         pointer_select_r <= 1'b0;
         user_flag_two_r <= 1'b0;
      end else begin
         mem_address_r <= active;
         pointer_select_r <= sel;
         user_flag_two_r <= aux_value[`AUX_FLAG_BIT];
      end
   end

   assign mem_address = mem_address_r;
   assign pointer_select = pointer_select_r;
   assign user_flag_two = user_flag_two_r;

   ////////////////////////////////////////////////////////////////////////
   // read channel

   logic arready_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic [9:0] rd_index;

   assign rd_index = s_axi_araddr[11:2];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= `RESP_OKAY;
      end else if (s_axi_arvalid && arready_r) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rresp_r <= `RESP_OKAY;
         case (rd_index)
            {2'b00, `IDX_POINTER_LOW}:
               rdata_r <= {24'h000000, active[7:0]};
            {2'b00, `IDX_POINTER_HIGH}:
               rdata_r <= {24'h000000, active[15:8]};
            {2'b00, `IDX_AUX_CONTROL}:
               rdata_r <= {24'h000000, aux_value};
            {2'b00, `IDX_CORE_OP}:
               rdata_r <= 32'h0000_0000;
            default: begin
               rdata_r <= 32'h0000_0000;
               rresp_r <= `RESP_SLVERR;
            end
         endcase
      end else if (rvalid_r) begin
         if (s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end else begin
         arready_r <= 1'b1;
      end
   end

   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   ////////////////////////////////////////////////////////////////////////
   // assertions

   sequence s_inc_aux;
      inc_aux && !wr_aux;
   endsequence

   property p_sel_toggle;
      @(posedge aclk) disable iff (!aresetn)
      s_inc_aux |=> (sel != $past(sel)) &&
         (aux_value[7:2] == $past(aux_value[7:2]));
   endproperty
   a_sel_toggle: assert property (p_sel_toggle)
      else $error("increment did not toggle only the select bit");

   property p_zero_bit;
      @(posedge aclk) disable iff (!aresetn)
      aux_value[`AUX_ZERO_BIT] == 1'b0;
   endproperty
   a_zero_bit: assert property (p_zero_bit)
      else $error("auxiliary bit 1 not zero");

   property p_reset_sel;
      @(posedge aclk) $rose(aresetn) |-> sel == 1'b0;
   endproperty
   a_reset_sel: assert property (p_reset_sel)
      else $error("select not zero after reset");

   property p_addr_follows;
      @(posedge aclk) disable iff (!aresetn)
      ##1 mem_address == $past(active);
   endproperty
   a_addr_follows: assert property (p_addr_follows)
      else $error("address output not tracking active pointer");

   property p_inc_ptr;
      @(posedge aclk) disable iff (!aresetn)
      inc_pointer |=> active == $past(active) + 16'h0001;
   endproperty
   a_inc_ptr: assert property (p_inc_ptr)
      else $error("pointer increment wrong");

   property p_low_write;
      @(posedge aclk) disable iff (!aresetn)
      wr_low |=> active[7:0] == $past(wdata_r[7:0]) &&
         active[15:8] == $past(active[15:8]);
   endproperty
   a_low_write: assert property (p_low_write)
      else $error("low byte write wrong");

   property p_high_write;
      @(posedge aclk) disable iff (!aresetn)
      wr_high |=> active[15:8] == $past(wdata_r[7:0]) &&
         active[7:0] == $past(active[7:0]);
   endproperty
   a_high_write: assert property (p_high_write)
      else $error("high byte write wrong");

   // the pointer left at one swap must come back unchanged at the next
   logic [15:0] left_r;
   logic [15:0] active_d_r;
   logic sel_d_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         left_r <= `POINTER_RESET;
         active_d_r <= `POINTER_RESET;
         sel_d_r <= 1'b0;
      end else begin
         active_d_r <= active;
         sel_d_r <= sel;
         if (sel != sel_d_r) begin
            left_r <= active_d_r;
         end
      end
   end

   sequence s_swap;
      sel != sel_d_r;
   endsequence

   property p_keep_inactive;
      @(posedge aclk) disable iff (!aresetn)
      s_swap |-> active == left_r;
   endproperty
   a_keep_inactive: assert property (p_keep_inactive)
      else $error("inactive pointer changed");

   property p_flag_write;
      @(posedge aclk) disable iff (!aresetn)
      wr_aux |=> ##1 user_flag_two == $past(wdata_r[3], 2);
   endproperty
   a_flag_write: assert property (p_flag_write)
      else $error("general flag not stored");

   property p_sel_write;
      @(posedge aclk) disable iff (!aresetn)
      wr_aux |=> sel == $past(wdata_r[0]);
   endproperty
   a_sel_write: assert property (p_sel_write)
      else $error("select write not applied");

endmodule

// file: bench/core_side_model.sv
`timescale 1ns/1ps
module core_side_model (
   input wire logic aclk,
   input wire logic [15:0] mem_address,
   output logic [15:0] seen_address
);
   // the core latches the active pointer as the address of its next access
   always_ff @(posedge aclk) begin
      seen_address <= mem_address;
   end
endmodule

// file: bench/test_dual_data_pointer_select.sv
`timescale 1ns/1ps
`include "primary_pointer_defs.svh"
module test_dual_data_pointer_select;
logic aclk = 0;
logic aresetn = 0;
logic [11:0] awaddr = 0;
logic [11:0] araddr = 0;
logic [31:0] wdata = 0;
logic [3:0] wstrb = 0;
logic awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
logic awready, wready, bvalid, arready, rvalid, sel_o, flag_o;
logic [1:0] bresp, rresp, eb;
logic [31:0] rdata;
logic [33:0] er;
logic [15:0] mem_address, seen_address;
logic [1:0] exp_b [$];
logic [33:0] exp_r [$];
logic [15:0] ptr [2];
logic [7:0] aux_m;
int n_fail = 0;
int n_tests = 0;
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin \
   n_fail++; $display("mismatch %s exp %h got %h", n, e, s); end end

always #2 aclk = ~aclk;

dual_data_pointer_select uut (
   .aclk(aclk),
   .aresetn(aresetn),
   .s_axi_awaddr(awaddr),
   .s_axi_awvalid(awvalid),
   .s_axi_awready(awready),
   .s_axi_wdata(wdata),
   .s_axi_wstrb(wstrb),
   .s_axi_wvalid(wvalid),
   .s_axi_wready(wready),
   .s_axi_bresp(bresp),
   .s_axi_bvalid(bvalid),
   .s_axi_bready(bready),
   .s_axi_araddr(araddr),
   .s_axi_arvalid(arvalid),
   .s_axi_arready(arready),
   .s_axi_rdata(rdata),
   .s_axi_rresp(rresp),
   .s_axi_rvalid(rvalid),
   .s_axi_rready(rready),
   .mem_address(mem_address),
   .pointer_select(sel_o),
   .user_flag_two(flag_o)
);

core_side_model core (
   .aclk(aclk),
   .mem_address(mem_address),
   .seen_address(seen_address)
);

////////////////////////////////////////////////////////////////////////////
function automatic logic [11:0] addr(input logic [7:0] i);
   return {2'b00, i, 2'b00};
endfunction

task automatic wr(input logic [11:0] a, input logic [31:0] d,
                  input logic [3:0] s, input logic [1:0] e);
   logic aw_ok, w_ok;
   aw_ok = 0;
   w_ok = 0;
   exp_b.push_back(e);
   awaddr <= a;
   wdata <= d;
   wstrb <= s;
   awvalid <= 1;
   wvalid <= 1;
   while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (awready === 1'b1 && !aw_ok) begin
         aw_ok = 1;
         awvalid <= 0;
      end
      if (wready === 1'b1 && !w_ok) begin
         w_ok = 1;
         wvalid <= 0;
      end
   end
   do @(posedge aclk); while (bvalid !== 1'b1);
endtask

task automatic rd(input logic [11:0] a, input logic [33:0] e);
   exp_r.push_back(e);
   araddr <= a;
   arvalid <= 1;
   do @(posedge aclk); while (arready !== 1'b1);
   arvalid <= 0;
   do @(posedge aclk); while (rvalid !== 1'b1);
endtask

// writes one register and moves the bench's own copy along with it
task automatic put(input logic [7:0] i, input logic [7:0] d);
   wr(addr(i), {24'h0, d}, 4'hf, `RESP_OKAY);
   case (i)
      `IDX_POINTER_LOW: ptr[aux_m[0]][7:0] = d;
      `IDX_POINTER_HIGH: ptr[aux_m[0]][15:8] = d;
      `IDX_AUX_CONTROL: aux_m = d & 8'hf9;
      default: if (d == 8'h01) ptr[aux_m[0]] += 16'h0001;
         else if (d == 8'h02) aux_m ^= 8'h01;
   endcase
endtask

task automatic check_all;
   rd(addr(`IDX_POINTER_LOW), {`RESP_OKAY, 24'h0, ptr[aux_m[0]][7:0]});
   rd(addr(`IDX_POINTER_HIGH), {`RESP_OKAY, 24'h0, ptr[aux_m[0]][15:8]});
   rd(addr(`IDX_AUX_CONTROL), {`RESP_OKAY, 24'h0, aux_m});
   repeat (3) @(posedge aclk);
   `CHK("mem_address", ptr[aux_m[0]], mem_address)
   `CHK("seen_address", ptr[aux_m[0]], seen_address)
   `CHK("pointer_select", aux_m[0], sel_o)
   `CHK("user_flag_two", aux_m[3], flag_o)
endtask

task automatic close_out;
   $display("comparisons %0d mismatches %0d", n_tests, n_fail);
   if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
   else $display("RESULT: FAIL");
   $finish;
endtask

////////////////////////////////////////////////////////////////////////////
// every answer on the bus is matched against the oldest note
always @(posedge aclk) begin
   if (bvalid === 1'b1 && bready) begin
      eb = exp_b.pop_front();
      `CHK("bresp", eb, bresp)
   end
   if (rvalid === 1'b1 && rready) begin
      er = exp_r.pop_front();
      `CHK("read", er, {rresp, rdata})
   end
end

initial begin
   #40000;
   n_fail++;
   close_out;
end

initial begin
   void'($urandom(32'h295ae6b7));
   ptr[0] = `POINTER_RESET;
   ptr[1] = `POINTER_RESET;
   aux_m = `AUX_RESET;
   repeat (20) @(posedge aclk);
   aresetn <= 1;
   check_all;
   // random loads, then a switch (even k) or a random aux control write (odd k): the other pointer must come back intact
   for (int k = 0; k < 12; k++) begin
      put(`IDX_POINTER_LOW, 8'($urandom));
      put(`IDX_POINTER_HIGH, 8'($urandom));
      if (k[0]) put(`IDX_AUX_CONTROL, 8'($urandom));
      else put(`IDX_CORE_OP, 8'h02);
      check_all;
   end
   // carry into the high byte, then the full wrap
   for (int k = 0; k < 2; k++) begin
      put(`IDX_POINTER_LOW, 8'hff);
      put(`IDX_POINTER_HIGH, k[0] ? 8'hff : 8'h00);
      put(`IDX_CORE_OP, 8'h01);
      check_all;
   end
   put(`IDX_AUX_CONTROL, 8'hff);
   check_all;
   put(`IDX_CORE_OP, 8'h02);
   check_all;
   put(`IDX_CORE_OP, 8'h02);
   check_all;
   // unused op code: neither pointer nor select may move
   put(`IDX_CORE_OP, 8'h03);
   check_all;
   wr(12'h004, 32'h0000005a, 4'hf, `RESP_SLVERR);
   rd(12'h004, {`RESP_SLVERR, 32'h0});
   // lane 0 off: accepted but ignored
   wr(addr(`IDX_POINTER_LOW), 32'h00000033, 4'he, `RESP_OKAY);
   check_all;
   close_out;
end
endmodule
